/* File: hw/cltr_pkg.sv */
package cltr_pkg;
  localparam logic [7:0] OP_REG_LOAD_IDX = 8'h87;
  localparam logic [7:0] OP_REG_STORE_IDX = 8'h97;
  localparam logic [7:0] OP_BIT_LOAD = 8'h47;
  localparam logic [7:0] OP_MEM_LOAD_IND = 8'hC3;
  localparam logic [7:0] OP_MEM_STORE_IND = 8'hD3;
  localparam logic [7:0] OP_MEM_LOAD_XS = 8'hE7;
  localparam logic [7:0] OP_MEM_STORE_XS = 8'hF7;
  localparam logic [7:0] OP_MEM_LOAD_XL = 8'hA7;
  localparam logic [7:0] OP_MEM_STORE_XL = 8'hB7;
  localparam logic [7:0] OP_LOAD_DEC = 8'hE2;
  localparam logic [7:0] OP_LOAD_INC = 8'hE3;
  localparam logic [7:0] OP_STORE_PRE_DEC = 8'hF2;
  localparam logic [7:0] OP_STORE_PRE_INC = 8'hF3;
  localparam logic [7:0] OP_WORD_LOAD = 8'hC4;
  localparam logic [3:0] DA_PROG_NIB = 4'h0;
  localparam logic [3:0] DA_DATA_NIB = 4'h1;
  localparam logic [4:0] CYC_IDX = 5'h06;
  localparam logic [4:0] CYC_BIT = 5'h06;
  localparam logic [4:0] CYC_IND = 5'h0A;
  localparam logic [4:0] CYC_XS = 5'h0C;
  localparam logic [4:0] CYC_XL = 5'h0E;
  localparam logic [4:0] CYC_PRE = 5'h0E;
  localparam logic [4:0] CYC_WORD = 5'h08;
  localparam logic [4:0] CYC_ILLEGAL = 5'h04;
  localparam logic [7:0] WORK_BASE = 8'hC0;
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } cltr_reg_req_t;
  typedef struct packed {
    logic req;
    logic we;
    logic data_space;
    logic [15:0] addr;
    logic [7:0] wdata;
  } cltr_mem_req_t;
endpackage

/* File: hw/cltr_core.sv */
`timescale 1ns/10ps
// How it works
// - indexed register address is base plus index
// - bit copy leaves other bits unchanged
// - second byte: register, bit, direction flag
// - even pair program memory, odd data memory
// - indirect memory load/store, ten cycles
// - short offset added to pair, twelve cycles
// - long offset low first, fourteen cycles
// - direct address, nibble picks memory space
// - indexed store leaves working registers unchanged
// - program writes only on reprogrammable parts
// - load then decrement pair, ten cycles
// - load then increment pair, ten cycles
// - pre-decrement pair then store, fourteen cycles
// - pre-increment pair then store, fourteen cycles
// - word copy between pairs, eight cycles
// - condition flags never change
// - source location never modified
module cltr_core #(
  parameter bit PROG_WRITABLE = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [31:0] instr_i,
  input wire logic [7:0] reg_rdata_i,
  input wire logic [7:0] mem_rdata_i,
  output cltr_pkg::cltr_reg_req_t reg_req_o,
  output cltr_pkg::cltr_mem_req_t mem_req_o,
  output logic busy_o,
  output logic done_o,
  output logic illegal_o
);
  import cltr_pkg::*;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_RD_A = 3'b001,
    S_RD_B = 3'b011,
    S_ACT = 3'b010,
    S_WB = 3'b110,
    S_WB2 = 3'b111,
    S_WAIT = 3'b101
  } cltr_state_t;

  cltr_state_t state_ff, nxt_state;
  logic [31:0] ins_ff, nxt_ins;
  logic [7:0] a_ff, nxt_a;
  logic [7:0] b_ff, nxt_b;
  logic [7:0] c_ff, nxt_c;
  logic [4:0] cnt_ff, nxt_cnt;
  cltr_reg_req_t reg_ff, nxt_reg;
  cltr_mem_req_t mem_ff, nxt_mem;
  logic busy_ff, nxt_busy;
  logic done_ff, nxt_done;
  logic ill_ff, nxt_ill;

  logic [7:0] opc, b1, b2, b3;
  logic [3:0] hi_n, lo_n;
  logic [15:0] pair;
  logic [15:0] maddr;
  logic [15:0] npair;
  logic is_da;

  function automatic logic [7:0] work_addr(input logic [3:0] r);
    work_addr = WORK_BASE | {4'h0, r};
  endfunction

  function automatic logic [4:0] cycles_of(input logic [7:0] op);
    case (op)
      OP_REG_LOAD_IDX, OP_REG_STORE_IDX: cycles_of = CYC_IDX;
      OP_BIT_LOAD: cycles_of = CYC_BIT;
      OP_MEM_LOAD_IND, OP_MEM_STORE_IND, OP_LOAD_DEC, OP_LOAD_INC: cycles_of = CYC_IND;
      OP_MEM_LOAD_XS, OP_MEM_STORE_XS: cycles_of = CYC_XS;
      OP_MEM_LOAD_XL, OP_MEM_STORE_XL: cycles_of = CYC_XL;
      OP_STORE_PRE_DEC, OP_STORE_PRE_INC: cycles_of = CYC_PRE;
      OP_WORD_LOAD: cycles_of = CYC_WORD;
      default: cycles_of = CYC_ILLEGAL;
    endcase
  endfunction

  function automatic logic is_mem_store(input logic [7:0] op);
    case (op)
      OP_MEM_STORE_IND, OP_MEM_STORE_XS, OP_MEM_STORE_XL: is_mem_store = 1'b1;
      OP_STORE_PRE_DEC, OP_STORE_PRE_INC: is_mem_store = 1'b1;
      default: is_mem_store = 1'b0;
    endcase
  endfunction

  // pair after the auto step; carry or borrow runs into the high byte
  function automatic logic [15:0] step_pair(input logic [7:0] op, input logic [15:0] p);
    case (op)
      OP_LOAD_INC, OP_STORE_PRE_INC: step_pair = p + 16'h0001;
      OP_LOAD_DEC, OP_STORE_PRE_DEC: step_pair = p - 16'h0001;
      default: step_pair = p;
    endcase
  endfunction

  // direct forms: nibble 0001 is data space; pair forms: odd pair code is data space
  function automatic logic space_of(input logic da, input logic [3:0] nib);
    if (da) begin
      space_of = (nib == DA_DATA_NIB);
    end else begin
      space_of = nib[0];
    end
  endfunction

  function automatic cltr_reg_req_t reg_write(input logic [7:0] addr, input logic [7:0] data);
    reg_write.we = 1'b1;
    reg_write.addr = addr;
    reg_write.wdata = data;
  endfunction

  function automatic cltr_mem_req_t mem_access(input logic wr, input logic space, input logic [15:0] addr,
                                               input logic [7:0] data);
    mem_access.req = 1'b1;
    mem_access.we = wr;
    mem_access.data_space = space;
    mem_access.addr = addr;
    mem_access.wdata = data;
  endfunction

  always_comb begin
    opc = ins_ff[31:24];
    b1 = ins_ff[23:16];
    b2 = ins_ff[15:8];
    b3 = ins_ff[7:0];
    hi_n = b1[7:4];
    lo_n = b1[3:0];
    is_da = ((opc == OP_MEM_LOAD_XL) || (opc == OP_MEM_STORE_XL)) && (lo_n[3:1] == DA_PROG_NIB[3:1]);
    pair = {a_ff, b_ff};
    npair = step_pair(opc, pair);
    maddr = pair;
    case (opc)
      OP_MEM_LOAD_XS, OP_MEM_STORE_XS: maddr = pair + {8'h00, b2};
      OP_MEM_LOAD_XL, OP_MEM_STORE_XL: maddr = is_da ? {b3, b2} : pair + {b3, b2};
      OP_STORE_PRE_DEC, OP_STORE_PRE_INC: maddr = npair;
      default: maddr = pair;
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_ins = ins_ff;
    nxt_a = a_ff;
    nxt_b = b_ff;
    nxt_c = c_ff;
    nxt_reg = '0;
    nxt_mem = '0;
    nxt_busy = busy_ff;
    nxt_done = 1'b0;
    nxt_ill = ill_ff;
    // register reads answer in the cycle the registered address is presented
    // walk: idle takes the word and presents read A
    // RD_A keeps A, presents B; RD_B keeps B, presents C
    // ACT keeps C and issues the register write or the memory request
    // WB writes the loaded byte, the second word byte or the stepped low byte
    // WB2 writes the stepped high byte of the pair
    // WAIT burns the rest of the cycle budget
    case (state_ff)
      S_IDLE: begin
        if (start_i) begin
          nxt_ins = instr_i;
          nxt_busy = 1'b1;
          nxt_ill = 1'b0;
          nxt_state = S_RD_A;
          case (instr_i[31:24])
            OP_REG_LOAD_IDX, OP_REG_STORE_IDX: nxt_reg.addr = work_addr(instr_i[19:16]);
            OP_BIT_LOAD: nxt_reg.addr = instr_i[15:8];
            OP_WORD_LOAD: nxt_reg.addr = instr_i[23:16]; // source pair high byte
            default: nxt_reg.addr = work_addr({instr_i[19:17], 1'b0}); // pair high byte
          endcase
        end
      end
      S_RD_A: begin
        nxt_a = reg_rdata_i;
        nxt_state = S_RD_B;
        case (opc)
          OP_REG_LOAD_IDX: nxt_reg.addr = work_addr(hi_n);
          OP_REG_STORE_IDX: nxt_reg.addr = work_addr(hi_n);
          OP_BIT_LOAD: nxt_reg.addr = work_addr(hi_n);
          OP_WORD_LOAD: nxt_reg.addr = b1 + 8'h01;
          default: nxt_reg.addr = work_addr({lo_n[3:1], 1'b1});
        endcase
      end
      S_RD_B: begin
        nxt_b = reg_rdata_i;
        nxt_state = S_ACT;
        case (opc)
          OP_REG_LOAD_IDX: nxt_reg.addr = b2 + a_ff;
          OP_REG_STORE_IDX, OP_BIT_LOAD, OP_WORD_LOAD: nxt_reg.addr = 8'h00;
          default: nxt_reg.addr = work_addr(hi_n);
        endcase
      end
      S_ACT: begin
        nxt_c = reg_rdata_i;
        nxt_state = S_WB;
        case (opc)
          OP_REG_LOAD_IDX: begin
            nxt_reg = '{we: 1'b1, addr: work_addr(hi_n), wdata: reg_rdata_i};
          end
          OP_REG_STORE_IDX: begin
            nxt_reg = '{we: 1'b1, addr: b2 + a_ff, wdata: b_ff};
          end
          OP_BIT_LOAD: begin
            // flag 0 loads working register bit 0 from register bit
            if (!b1[0]) begin
              nxt_reg = '{we: 1'b1, addr: work_addr(hi_n), wdata: {b_ff[7:1], a_ff[b1[3:1]]}};
            end else begin
              nxt_reg.we = 1'b1;
              nxt_reg.addr = b2;
              nxt_reg.wdata = a_ff;
              nxt_reg.wdata[b1[3:1]] = b_ff[0];
            end
          end
          OP_WORD_LOAD: begin
            nxt_reg = reg_write(b2, a_ff);
          end
          OP_MEM_LOAD_IND, OP_MEM_LOAD_XS, OP_MEM_LOAD_XL, OP_LOAD_DEC, OP_LOAD_INC: begin
            nxt_mem = mem_access(1'b0, space_of(is_da, lo_n), maddr, 8'h00);
            if ((opc == OP_LOAD_DEC) || (opc == OP_LOAD_INC)) begin
              // low byte of the stepped pair goes out while memory answers
              nxt_reg = reg_write(work_addr({lo_n[3:1], 1'b1}), npair[7:0]);
            end
            nxt_ill = (opc == OP_MEM_LOAD_XL) && !is_da && (lo_n[3:1] == 3'h0);
          end
          default: begin
            if (is_mem_store(opc)) begin
              nxt_mem = mem_access(1'b1, space_of(is_da, lo_n), maddr, reg_rdata_i);
              nxt_mem.req = nxt_mem.data_space || PROG_WRITABLE;
              nxt_ill = (opc == OP_MEM_STORE_XL) && !is_da && (lo_n[3:1] == 3'h0);
            end else begin
              nxt_ill = 1'b1;
            end
          end
        endcase
      end
      S_WB: begin
        nxt_state = S_WAIT;
        case (opc)
          OP_WORD_LOAD: nxt_reg = reg_write(b2 + 8'h01, b_ff);
          OP_MEM_LOAD_IND, OP_MEM_LOAD_XS, OP_MEM_LOAD_XL, OP_LOAD_DEC, OP_LOAD_INC: begin
            nxt_reg = '{we: 1'b1, addr: work_addr(hi_n), wdata: mem_rdata_i};
            if ((opc == OP_LOAD_DEC) || (opc == OP_LOAD_INC)) begin
              nxt_state = S_WB2;
            end
          end
          OP_STORE_PRE_DEC, OP_STORE_PRE_INC: begin
            nxt_reg = '{we: 1'b1, addr: work_addr({lo_n[3:1], 1'b1}), wdata: maddr[7:0]};
            nxt_state = S_WB2;
          end
          default: nxt_state = S_WAIT;
        endcase
      end
      S_WB2: begin
        // high byte of the stepped pair; the low byte went out earlier
        nxt_state = S_WAIT;
        nxt_reg = reg_write(work_addr({lo_n[3:1], 1'b0}), npair[15:8]);
      end
      S_WAIT: begin
        // leave so that the next start lands one budget after this one; the four-cycle illegal budget still takes six cycles
        if (cnt_ff <= 5'h01) begin
          nxt_state = S_IDLE;
          nxt_busy = 1'b0;
          nxt_done = 1'b1;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
  end

  // instruction cycle budget, loaded on start and run down while busy
  always_comb begin
    nxt_cnt = cnt_ff;
    if ((state_ff == S_IDLE) && start_i) begin
      nxt_cnt = cycles_of(instr_i[31:24]) - 5'h01;
    end else if ((state_ff != S_IDLE) && (cnt_ff != 5'h00)) begin
      nxt_cnt = cnt_ff - 5'h01;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= S_IDLE;
      ins_ff <= '0;
      a_ff <= '0;
      b_ff <= '0;
      c_ff <= '0;
      reg_ff <= '0;
      mem_ff <= '0;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      ill_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      ins_ff <= nxt_ins;
      a_ff <= nxt_a;
      b_ff <= nxt_b;
      c_ff <= nxt_c;
      reg_ff <= nxt_reg;
      mem_ff <= nxt_mem;
      busy_ff <= nxt_busy;
      done_ff <= nxt_done;
      ill_ff <= nxt_ill;
    end
  end

  // no flag register is touched by this group
  assign reg_req_o = reg_ff;
  assign mem_req_o = mem_ff;
  assign busy_o = busy_ff;
  assign done_o = done_ff;
  assign illegal_o = ill_ff;
endmodule

/* File: tb/cltr_core_chk.sv */
`timescale 1ns/10ps
module cltr_chk
  import cltr_pkg::*;
#(
  parameter bit PROG_WRITABLE = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic start_i,
  input wire logic [31:0] instr_i,
  input wire cltr_pkg::cltr_mem_req_t mem_req_o,
  input wire logic busy_o,
  input wire logic done_o,
  input wire logic illegal_o
);
  logic take;
  logic mwr;
  assign take = start_i && !busy_o;
  assign mwr = mem_req_o.req && mem_req_o.we;
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  AST_BUSY_RISE: assert property (take |=> busy_o)
    else $error("busy not raised after start");
  AST_DONE_BOUND: assert property (take |-> ##[5:20] done_o)
    else $error("instruction did not finish in time");
  AST_DONE_PULSE: assert property (done_o |=> !done_o)
    else $error("done longer than one cycle");
  AST_BUSY_FALL: assert property ($fell(busy_o) |-> done_o || $past(done_o))
    else $error("busy dropped without done");
  AST_PROG_WR: assert property (mwr |-> mem_req_o.data_space || PROG_WRITABLE)
    else $error("program store on fixed memory");
  AST_ILL_CLR: assert property (take |=> !illegal_o)
    else $error("illegal flag not cleared");
  AST_LOAD_NOWR: assert property (take && instr_i[31:24] inside {8'hC3, 8'hE7, 8'hA7, 8'hE2, 8'hE3}
    |=> !mwr [*8]) else $error("memory load wrote memory");
  AST_STORE_WR: assert property (take && instr_i[31:24] inside {8'hD3, 8'hF7, 8'hF2, 8'hF3}
    |-> ##[1:20] mwr) else $error("memory store never issued");
endmodule

/* File: tb/cltr_mem_model.sv */
`timescale 1ns/10ps
module cltr_mem_model
  import cltr_pkg::*;
(
  input wire logic clk_i,
  input wire cltr_pkg::cltr_reg_req_t reg_req_i,
  input wire cltr_pkg::cltr_mem_req_t mem_req_i,
  output logic [7:0] reg_rdata_o,
  output logic [7:0] mem_rdata_o
);
  logic [7:0] rf [256];
  logic [24:0] last_wr = '0;
  int wr_cnt = 0;
  logic [7:0] idle_ff = 8'h00;
  // both read ports answer in the cycle the registered request stands
  assign reg_rdata_o = rf[reg_req_i.addr];
  // an idle read bus toggles so a stale byte is never mistaken for data
  assign mem_rdata_o = (mem_req_i.req && !mem_req_i.we) ?
    (mem_req_i.addr[7:0] ^ mem_req_i.addr[15:8] ^ {mem_req_i.data_space, 7'h35}) : idle_ff;
  always @(posedge clk_i) begin
    idle_ff <= ~idle_ff;
    if (reg_req_i.we)
      rf[reg_req_i.addr] <= reg_req_i.wdata;
    if (mem_req_i.req && mem_req_i.we) begin
      last_wr <= {mem_req_i.data_space, mem_req_i.addr, mem_req_i.wdata};
      wr_cnt <= wr_cnt + 1;
    end
  end
endmodule

/* File: tb/tb_cpu_load_transfer_instructions.sv */
`timescale 1ns/10ps
module tb_cpu_load_transfer_instructions;
  import cltr_pkg::*;
  logic clk_i, rst_b_i, start_i, busy_o, done_o, illegal_o, exp_ill;
  logic [31:0] instr_i, seed;
  logic [7:0] reg_rdata_i, mem_rdata_i;
  logic [7:0] exp_rf [256];
  logic [24:0] exp_wr;
  cltr_reg_req_t reg_req_o;
  cltr_mem_req_t mem_req_o;
  int exp_cnt, num_errors, checks;
  cltr_core uut (.clk_i, .rst_b_i, .start_i, .instr_i, .reg_rdata_i, .mem_rdata_i, .reg_req_o, .mem_req_o,
    .busy_o, .done_o, .illegal_o);
  cltr_mem_model ptn (.clk_i, .reg_req_i(reg_req_o), .mem_req_i(mem_req_o), .reg_rdata_o(reg_rdata_i),
    .mem_rdata_o(mem_rdata_i));
  function automatic logic [7:0] ra(input logic [3:0] n);
    return WORK_BASE | {4'h0, n};
  endfunction
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic mwr(input logic [15:0] a, input logic s, input logic [7:0] d);
    exp_wr = {s, a, d};
    exp_cnt++;
  endtask
  task automatic predict(input logic [31:0] ins);
    logic [7:0] op, b1, b2, b3, d, hp, lp, x;
    logic [15:0] a;
    logic s;
    {op, b1, b2, b3} = ins;
    d = ra(b1[7:4]);
    hp = ra(b1[3:0] & 4'hE);
    lp = hp | 8'h01;
    x = b2 + exp_rf[ra(b1[3:0])];
    a = {exp_rf[hp], exp_rf[lp]};
    s = b1[0];
    exp_ill = 1'b0;
    case (op)
      OP_REG_LOAD_IDX: exp_rf[d] = exp_rf[x];
      OP_REG_STORE_IDX: exp_rf[x] = exp_rf[d];
      OP_BIT_LOAD: begin
        if (s)
          exp_rf[b2][b1[3:1]] = exp_rf[d][0];
        else
          exp_rf[d][0] = exp_rf[b2][b1[3:1]];
      end
      OP_MEM_LOAD_IND: exp_rf[d] = {pat(a, s)};
      OP_MEM_STORE_IND: mwr(a, s, exp_rf[d]);
      OP_MEM_LOAD_XS: exp_rf[d] = pat(a + 16'(b2), s);
      OP_MEM_STORE_XS: mwr(a + 16'(b2), s, exp_rf[d]);
      OP_MEM_LOAD_XL, OP_MEM_STORE_XL: begin
        a = (b1[3:1] == 3'h0) ? {b3, b2} : a + {b3, b2};
        if (op == OP_MEM_LOAD_XL)
          exp_rf[d] = pat(a, s);
        else
          mwr(a, s, exp_rf[d]);
      end
      OP_LOAD_DEC, OP_LOAD_INC: begin
        exp_rf[d] = pat(a, s);
        {exp_rf[hp], exp_rf[lp]} = op[0] ? a + 16'h0001 : a - 16'h0001;
      end
      OP_STORE_PRE_DEC, OP_STORE_PRE_INC: begin
        a = op[0] ? a + 16'h0001 : a - 16'h0001;
        {exp_rf[hp], exp_rf[lp]} = a;
        mwr(a, s, exp_rf[d]);
      end
      OP_WORD_LOAD: begin
        exp_rf[b2] = exp_rf[b1];
        exp_rf[b2 + 8'h01] = exp_rf[b1 + 8'h01];
      end
      default: exp_ill = 1'b1;
    endcase
  endtask
  function automatic logic [7:0] pat(input logic [15:0] a, input logic s);
    return a[7:0] ^ a[15:8] ^ {s, 7'h35};
  endfunction
  task automatic run(input logic [31:0] ins);
    int n;
    predict(ins);
    @(posedge clk_i);
    start_i <= 1'b1;
    instr_i <= ins;
    @(posedge clk_i);
    start_i <= 1'b0;
    for (n = 0; n < 40 && done_o !== 1'b1; n++)
      @(posedge clk_i);
    @(posedge clk_i);
    chk_val(32'(n < 40), 32'h1, "no done");
    chk_val(32'(illegal_o), 32'(exp_ill), "illegal flag");
    chk_val(ptn.wr_cnt, exp_cnt, "store count");
    chk_val(32'(ptn.last_wr), 32'(exp_wr), "store");
    for (int i = 0; i < 256; i++)
      chk_val(32'(ptn.rf[i]), 32'(exp_rf[i]), "register");
  endtask
  function automatic logic [31:0] rand_ins(input int k);
    logic [7:0] ops [14] = '{8'h87, 8'h97, 8'h47, 8'hC3, 8'hD3, 8'hE7, 8'hF7, 8'hA7, 8'hB7, 8'hE2, 8'hE3,
      8'hF2, 8'hF3, 8'hC4};
    logic [31:0] r;
    r = rnd();
    r[31:24] = ops[k % 14];
    // keep the data register out of the address pair
    if (r[23:21] == r[19:17])
      r[23] = ~r[23];
    // short offsets stay positive; pair codes 0 and 1 of the long forms mean direct address
    if (r[31:24] == OP_MEM_LOAD_XS || r[31:24] == OP_MEM_STORE_XS)
      r[15] = 1'b0;
    if (r[31:24] == OP_WORD_LOAD)
      r = r & 32'hFFFE_FEFF;
    return r;
  endfunction
  task automatic close_out();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    repeat (4000) @(posedge clk_i);
    num_errors++;
    close_out();
  end
  initial begin
    {rst_b_i, start_i, instr_i, exp_wr, exp_ill} = '0;
    {exp_cnt, num_errors, checks} = '0;
    seed = 32'd19;
    foreach (exp_rf[i])
      exp_rf[i] = 8'(rnd());
    exp_rf[8'hC6] = 8'h30;
    exp_rf[8'hC7] = 8'h00;
    ptn.rf = exp_rf;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    run({OP_STORE_PRE_DEC, 24'h06_0000});
    run({OP_STORE_PRE_INC, 24'h07_0000});
    run({OP_LOAD_DEC, 24'h86_0000});
    run({OP_LOAD_INC, 24'h87_0000});
    run({OP_MEM_LOAD_XL, 24'h20_0411});
    run({OP_MEM_STORE_XL, 24'h31_0511});
    run({OP_MEM_LOAD_XL, 24'h22_FF00});
    run(32'h0000_0000);
    for (int k = 0; k < 70; k++)
      run(rand_ins(k));
    close_out();
  end
endmodule
bind cltr_core cltr_chk #(.PROG_WRITABLE(PROG_WRITABLE)) chk (.clk_i, .rst_b_i, .start_i, .instr_i, .mem_req_o,
  .busy_o, .done_o, .illegal_o);
